// *** hw/wrc_top.sv ***
/*
 * Watchdog with windowed arming, reset sequencer with vector choice,
 * clock quality handling with self-clock mode, and three clock events.
 * Assumes: synchronous inputs on mclk; qual_ok pulses once per clock
 * quality check window with qual_good; pll_lock and clk_loss are levels
 * from analog monitors; reset_pin_in reads the open-drain reset pin.
 */
// Overview of operation
// [R01] While enabled, 0x0055 then 0x00AA to arm register restarts watchdog period.
// [R02] Watchdog period expiring without completed arming starts system reset.
// [R03] Any other value written to the arm register resets immediately.
// [R04] Windowed mode: arming only in last quarter; earlier write resets.
// [R05] After sequence: no clock monitor fail but watchdog latched picks watchdog vector.
// [R06] Power-on or low-voltage reset starts clock quality check, then sequence.
// [R07] Fifty failed check windows make the sequence run in self-clock mode.
// [R08] Periodic interval elapse raises tick interrupt unless its enable is zero.
// [R09] Tick flag set on every timeout, cleared only by writing one.
// [R10] Tick counter keeps running in pseudo-stop when its enable bit is one.
// [R11] Lock change either direction raises lock interrupt unless enable is zero.
// [R12] Lock flag set on every change, cleared only by writing one.
// [R13] Self-clock entry or exit raises interrupt; change only with self-clock enable.
// [R14] Self-clock entered on failed check or, with monitor on, clock loss.
// [R15] Self-clock flag set on each change, cleared by writing one; enable gates.
// [R16] Oscillator type select captured at reset pin rise; 0 low-power, 1 full-swing.
// [R17] Every reset drives pin low 128 cycles plus sync (power-on, low-voltage and stop wake also through the quality check), then waits 64 before sampling.
// [R18] Each interrupt request is flag AND enable, held until flag cleared.
`default_nettype none
`include "wrc_map.svh"

module wrc_top #(
    parameter int WD_BASE_CYC = 16384,
    parameter int TICK_BASE_CYC = 1024
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic por_event,
    input wire logic lvr_event,
    input wire logic stop_wake,
    input wire logic pseudo_stop,
    input wire logic qual_ok,
    input wire logic qual_good,
    input wire logic clk_loss,
    input wire logic pll_lock,
    input wire logic oscillator_type_select,
    input wire logic reset_pin_in,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    output logic sys_reset,
    output logic self_clock_mode,
    output logic osc_full_swing,
    output logic irq
);
    localparam int WD_CW = 32;
    localparam int SEQ_CW = 8;
    localparam logic [SEQ_CW-1:0] DRIVE_END =
        SEQ_CW'(`WRC_RST_DRIVE_CYC + `WRC_RST_SYNC_CYC - 1);
    localparam logic [SEQ_CW-1:0] WAIT_END = SEQ_CW'(`WRC_RST_WAIT_CYC - 1);

    initial
    begin
        if (WD_BASE_CYC < 4 || TICK_BASE_CYC < 1)
            $error("wrc_top: base periods too small");
    end

    // period of rate code r: base shifted by r-1; code 0 means off
    function automatic logic [WD_CW-1:0] wd_period(input logic [2:0] r);
        wd_period = WD_CW'(WD_BASE_CYC) << (r - 3'h1);
    endfunction

    // ---------------- registers ----------------
    logic [3:0] wd_ctrl_q, wd_ctrl_d;
    logic [3:0] tick_rate_q, tick_rate_d;
    logic [2:0] clk_ctrl_q, clk_ctrl_d;
    logic [2:0] irq_en_q, irq_en_d;
    logic [2:0] flag_q, flag_d;
    logic [15:0] rdata_q, rdata_d;
    logic irq_q, irq_d;

    // ---------------- watchdog / tick / clock state ----------------
    logic [WD_CW-1:0] wd_cnt_q, wd_cnt_d;
    logic arm_half_q, arm_half_d;
    logic wd_latch_q, wd_latch_d;
    logic cm_latch_q, cm_latch_d;
    logic [WD_CW-1:0] tick_cnt_q, tick_cnt_d;
    logic lock_q, lock_d;
    logic scm_q, scm_d;
    logic [5:0] qwin_q, qwin_d;

    // ---------------- reset sequencer ----------------
    wrc_pkg::wrc_rst_t rs_q, rs_d;
    logic [SEQ_CW-1:0] seq_q, seq_d;
    logic pin_low_q, pin_low_d;
    logic sysrst_q, sysrst_d;
    logic pin_prev_q, pin_prev_d;
    logic osc_q, osc_d;
    wrc_pkg::wrc_vec_t vec_q, vec_d;

    logic wr_arm, bad_write, wd_enabled, wd_expire, in_window, reset_req;
    logic tick_ev, lock_ev, scm_ev;
    logic [WD_CW-1:0] wd_per;

    always_comb
    begin
        wd_enabled = wd_ctrl_q[`WRC_WD_RATE_MSB:`WRC_WD_RATE_LSB] != 3'h0;
        wd_per = wd_period(wd_ctrl_q[`WRC_WD_RATE_MSB:`WRC_WD_RATE_LSB]);
        wr_arm = reg_wr && reg_addr == `WRC_OFF_WDOG_ARM && rs_q == wrc_pkg::WRC_RS_RUN;
        // counter counts up; last quarter starts at three quarters of the period
        in_window = !wd_ctrl_q[`WRC_WD_WINDOW_BIT]
            || wd_cnt_q >= wd_per - (wd_per >> 2);
        // [R03] illegal value
        bad_write = wr_arm && reg_wdata != `WRC_ARM_FIRST && reg_wdata != `WRC_ARM_SECOND;
        // [R04] premature write in window mode
        if (wr_arm && wd_enabled && !in_window)
            bad_write = 1'b1;
        // [R02] period elapsed
        wd_expire = wd_enabled && rs_q == wrc_pkg::WRC_RS_RUN && wd_cnt_q >= wd_per - 1;
        reset_req = wd_expire || bad_write
            || (clk_loss && clk_ctrl_q[`WRC_CC_MON_EN_BIT]
                && !clk_ctrl_q[`WRC_CC_SELF_EN_BIT] && rs_q == wrc_pkg::WRC_RS_RUN);

        wd_cnt_d = wd_cnt_q;
        arm_half_d = arm_half_q;
        if (!wd_enabled || rs_q != wrc_pkg::WRC_RS_RUN)
        begin
            wd_cnt_d = '0;
            arm_half_d = 1'b0;
        end
        else
        begin
            wd_cnt_d = wd_cnt_q + 1'b1;
            if (wr_arm && !bad_write)
            begin
                // [R01] ordered pair restarts the period
                if (reg_wdata == `WRC_ARM_FIRST)
                    arm_half_d = 1'b1;
                else if (arm_half_q)
                begin
                    arm_half_d = 1'b0;
                    wd_cnt_d = '0;
                end
            end
        end

        // [R10] tick pauses in pseudo-stop unless its enable is set
        tick_cnt_d = tick_cnt_q;
        tick_ev = 1'b0;
        if (tick_rate_q == 4'h0)
            tick_cnt_d = '0;
        else if (!pseudo_stop || clk_ctrl_q[`WRC_CC_PSTOP_TICK_BIT])
        begin
            tick_cnt_d = tick_cnt_q + 1'b1;
            // [R08] interval elapsed
            if (tick_cnt_q >= (WD_CW'(TICK_BASE_CYC) << tick_rate_q) - 1)
            begin
                tick_cnt_d = '0;
                tick_ev = 1'b1;
            end
        end

        // [R11] lock change either direction
        lock_d = pll_lock;
        lock_ev = pll_lock != lock_q;

        // [R14] self-clock entry and exit, [R13] only with self-clock enable
        scm_d = scm_q;
        qwin_d = qwin_q;
        if (clk_ctrl_q[`WRC_CC_SELF_EN_BIT])
        begin
            if (clk_loss && clk_ctrl_q[`WRC_CC_MON_EN_BIT])
                scm_d = 1'b1;
            else if (qual_ok && qual_good)
                scm_d = 1'b0;
        end
        if (rs_q == wrc_pkg::WRC_RS_QUAL && qual_ok)
        begin
            qwin_d = qwin_q + 6'h01;
            // [R07] fifty failed windows
            if (!qual_good && qwin_q == 6'(`WRC_QUAL_WINDOWS - 1)
                && clk_ctrl_q[`WRC_CC_SELF_EN_BIT])
                scm_d = 1'b1;
        end
        if (rs_q != wrc_pkg::WRC_RS_QUAL)
            qwin_d = '0;
        scm_ev = scm_d != scm_q;
    end

    // reset sequencer
    always_comb
    begin
        rs_d = rs_q;
        seq_d = seq_q;
        pin_low_d = pin_low_q;
        sysrst_d = sysrst_q;
        pin_prev_d = reset_pin_in;
        osc_d = osc_q;
        vec_d = vec_q;
        // cause latches gather until the vector has been chosen
        wd_latch_d = wd_latch_q | wd_expire;
        cm_latch_d = cm_latch_q | (reset_req && !wd_expire && !bad_write);
        // [R16] capture at rising edge of the reset pin
        if (reset_pin_in && !pin_prev_q)
            osc_d = oscillator_type_select;
        if (por_event || lvr_event || stop_wake)
        begin
            // [R06] clock quality check before the sequence
            rs_d = wrc_pkg::WRC_RS_QUAL;
            sysrst_d = 1'b1;
            pin_low_d = 1'b1;
            seq_d = '0;
        end
        else
        begin
            unique case (rs_q)
                wrc_pkg::WRC_RS_QUAL:
                    if (qual_ok && (qual_good || scm_d
                        || qwin_q == 6'(`WRC_QUAL_WINDOWS - 1)))
                    begin
                        rs_d = wrc_pkg::WRC_RS_DRIVE;
                        seq_d = '0;
                    end
                // [R17] pin low for drive plus sync cycles
                wrc_pkg::WRC_RS_DRIVE:
                begin
                    seq_d = seq_q + 1'b1;
                    if (seq_q == DRIVE_END)
                    begin
                        pin_low_d = 1'b0;
                        seq_d = '0;
                        rs_d = wrc_pkg::WRC_RS_WAIT;
                    end
                end
                // [R17] wait then sample pin, [R05] pick vector
                wrc_pkg::WRC_RS_WAIT:
                begin
                    seq_d = seq_q + 1'b1;
                    if (seq_q == WAIT_END && reset_pin_in)
                    begin
                        rs_d = wrc_pkg::WRC_RS_RUN;
                        sysrst_d = 1'b0;
                        wd_latch_d = 1'b0;
                        cm_latch_d = 1'b0;
                        if (cm_latch_q)
                            vec_d = wrc_pkg::WRC_VEC_CLKMON;
                        else if (wd_latch_q)
                            vec_d = wrc_pkg::WRC_VEC_WDOG;
                        else
                            vec_d = wrc_pkg::WRC_VEC_POR;
                    end
                    else if (seq_q == WAIT_END)
                        seq_d = seq_q;
                end
                wrc_pkg::WRC_RS_RUN:
                    if (reset_req || !reset_pin_in)
                    begin
                        rs_d = wrc_pkg::WRC_RS_DRIVE;
                        sysrst_d = 1'b1;
                        pin_low_d = 1'b1;
                        seq_d = '0;
                    end
            endcase
        end
    end

    // register file, flags and interrupt
    always_comb
    begin
        logic [2:0] clr;
        clr = '0;
        wd_ctrl_d = wd_ctrl_q;
        tick_rate_d = tick_rate_q;
        clk_ctrl_d = clk_ctrl_q;
        irq_en_d = irq_en_q;
        if (reg_wr)
        begin
            unique case (reg_addr)
                `WRC_OFF_WDOG_CTRL: wd_ctrl_d = reg_wdata[3:0];
                `WRC_OFF_TICK_CTRL: tick_rate_d = reg_wdata[3:0];
                `WRC_OFF_CLK_CTRL: clk_ctrl_d = reg_wdata[2:0];
                `WRC_OFF_IRQ_CLR: clr = reg_wdata[2:0];
                `WRC_OFF_IRQ_EN: irq_en_d = reg_wdata[2:0];
                default: ;
            endcase
        end
        // a reset sequence restores configuration but keeps the flags
        if (rs_q == wrc_pkg::WRC_RS_RUN && rs_d != wrc_pkg::WRC_RS_RUN)
        begin
            wd_ctrl_d = '0;
            tick_rate_d = '0;
            clk_ctrl_d = 3'(`WRC_CLK_CTRL_RST);
            irq_en_d = '0;
        end
        // [R09] [R12] [R15] set wins over write-one clear
        flag_d = (flag_q & ~clr);
        flag_d[`WRC_IRQ_TICK_BIT] = flag_d[`WRC_IRQ_TICK_BIT] | tick_ev;
        flag_d[`WRC_IRQ_LOCK_BIT] = flag_d[`WRC_IRQ_LOCK_BIT] | lock_ev;
        flag_d[`WRC_IRQ_SELF_BIT] = flag_d[`WRC_IRQ_SELF_BIT] | scm_ev;
        // [R18] flag AND enable
        irq_d = |(flag_d & irq_en_d);
        rdata_d = '0;
        if (reg_rd)
        begin
            unique case (reg_addr)
                `WRC_OFF_WDOG_CTRL: rdata_d = {12'h000, wd_ctrl_q};
                `WRC_OFF_TICK_CTRL: rdata_d = {12'h000, tick_rate_q};
                `WRC_OFF_CLK_CTRL: rdata_d = {13'h0000, clk_ctrl_q};
                `WRC_OFF_IRQ_STAT: rdata_d = {13'h0000, flag_q};
                `WRC_OFF_IRQ_EN: rdata_d = {13'h0000, irq_en_q};
                `WRC_OFF_STATUS:
                    rdata_d = {11'h000, lock_q, 2'(vec_q), osc_q, scm_q};
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wd_ctrl_q <= '0;
            tick_rate_q <= '0;
            clk_ctrl_q <= 3'(`WRC_CLK_CTRL_RST);
            irq_en_q <= '0;
            flag_q <= '0;
            rdata_q <= '0;
            irq_q <= 1'b0;
            wd_cnt_q <= '0;
            arm_half_q <= 1'b0;
            wd_latch_q <= 1'b0;
            cm_latch_q <= 1'b0;
            tick_cnt_q <= '0;
            lock_q <= 1'b0;
            scm_q <= 1'b0;
            qwin_q <= '0;
            rs_q <= wrc_pkg::WRC_RS_QUAL;
            seq_q <= '0;
            pin_low_q <= 1'b1;
            sysrst_q <= 1'b1;
            pin_prev_q <= 1'b0;
            osc_q <= 1'b0;
            vec_q <= wrc_pkg::WRC_VEC_POR;
        end
        else
        begin
            wd_ctrl_q <= wd_ctrl_d;
            tick_rate_q <= tick_rate_d;
            clk_ctrl_q <= clk_ctrl_d;
            irq_en_q <= irq_en_d;
            flag_q <= flag_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
            wd_cnt_q <= wd_cnt_d;
            arm_half_q <= arm_half_d;
            wd_latch_q <= wd_latch_d;
            cm_latch_q <= cm_latch_d;
            tick_cnt_q <= tick_cnt_d;
            lock_q <= lock_d;
            scm_q <= scm_d;
            qwin_q <= qwin_d;
            rs_q <= rs_d;
            seq_q <= seq_d;
            pin_low_q <= pin_low_d;
            sysrst_q <= sysrst_d;
            pin_prev_q <= pin_prev_d;
            osc_q <= osc_d;
            vec_q <= vec_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe = pin_low_q;
    assign sys_reset = sysrst_q;
    assign self_clock_mode = scm_q;
    assign osc_full_swing = osc_q;
    assign irq = irq_q;
endmodule // wrc_top
`default_nettype wire

// *** hw/wrc_map.svh ***
/*
 * Register offsets, field positions, reset values and timing counts of the
 * watchdog, reset and clock-event block.
 * Assumes inclusion by bare name from the block's design file.
 */
`ifndef WRC_MAP_SVH
`define WRC_MAP_SVH

// register word offsets (byte address = offset)
`define WRC_OFF_WDOG_CTRL 4'h0
`define WRC_OFF_WDOG_ARM 4'h1
`define WRC_OFF_TICK_CTRL 4'h2
`define WRC_OFF_CLK_CTRL 4'h3
`define WRC_OFF_IRQ_STAT 4'h4
`define WRC_OFF_IRQ_CLR 4'h5
`define WRC_OFF_IRQ_EN 4'h6
`define WRC_OFF_STATUS 4'h7

// watchdog control fields
`define WRC_WD_RATE_LSB 0
`define WRC_WD_RATE_MSB 2
`define WRC_WD_WINDOW_BIT 3

// clock control fields
`define WRC_CC_MON_EN_BIT 0
`define WRC_CC_SELF_EN_BIT 1
`define WRC_CC_PSTOP_TICK_BIT 2
`define WRC_CLK_CTRL_RST 16'h0003

// interrupt status, clear and enable bits
`define WRC_IRQ_TICK_BIT 0
`define WRC_IRQ_LOCK_BIT 1
`define WRC_IRQ_SELF_BIT 2

// status fields
`define WRC_ST_SELF_BIT 0
`define WRC_ST_OSC_TYPE_BIT 1
`define WRC_ST_VEC_LSB 2
`define WRC_ST_VEC_MSB 3
`define WRC_ST_LOCK_BIT 4

// arming values
`define WRC_ARM_FIRST 16'h0055
`define WRC_ARM_SECOND 16'h00AA

// reset sequence lengths in system clock cycles, quality check count in windows
`define WRC_RST_DRIVE_CYC 128
`define WRC_RST_SYNC_CYC 3
`define WRC_RST_WAIT_CYC 64
`define WRC_QUAL_WINDOWS 50

`endif

// *** hw/wrc_pkg.sv ***
/*
 * Types of the watchdog, reset and clock-event block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package wrc_pkg;
    typedef enum logic [1:0] {WRC_VEC_POR, WRC_VEC_CLKMON, WRC_VEC_WDOG} wrc_vec_t;
    typedef enum logic [2:0] {
        WRC_RS_QUAL, WRC_RS_DRIVE, WRC_RS_WAIT, WRC_RS_RUN
    } wrc_rst_t;
endpackage
`default_nettype wire

// *** bench/wrc_osc_model.sv ***
/*
 * Oscillator side model: quality check windows, PLL lock, clock loss
 * and the pulled-up reset pin.
 * Assumes the bench commands every fault through its inputs.
 */
`default_nettype none
module wrc_osc_model (
    input wire logic mclk,
    input wire logic osc_bad,
    input wire logic lock_cmd,
    input wire logic loss_cmd,
    input wire logic reset_pin_oe,
    output logic qual_ok,
    output logic qual_good,
    output logic pll_lock,
    output logic clk_loss,
    output wire logic reset_pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] win_q = 2'h0;
    // pull-up: the pin reads high unless the block drives it low
    assign reset_pin_in = !reset_pin_oe;
    initial
    begin
        qual_ok = 1'b0;
        qual_good = 1'b0;
        pll_lock = 1'b0;
        clk_loss = 1'b0;
    end
    always @(posedge mclk)
    begin
        win_q <= win_q + 2'h1;
        qual_ok <= win_q == 2'h3;
        // outside a window the verdict line wanders, so nothing stale is trusted
        qual_good <= (win_q == 2'h3) ? !osc_bad : win_q[0];
        pll_lock <= lock_cmd;
        clk_loss <= loss_cmd;
    end
endmodule // wrc_osc_model
`default_nettype wire

// *** bench/wrc_top_chk.sv ***
/*
 * Assertion checker of the watchdog, reset and clock-event block.
 * Assumes binding to the top module, seeing its ports only.
 */
`default_nettype none
`include "wrc_map.svh"
module wrc_top_chk #(
    parameter int WD_BASE_CYC = 16,
    parameter int TICK_BASE_CYC = 4
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic oscillator_type_select,
    input wire logic reset_pin_in,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe,
    input wire logic sys_reset,
    input wire logic self_clock_mode,
    input wire logic osc_full_swing,
    input wire logic irq
);
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    wire logic bad_wr = reg_wr && reg_addr == `WRC_OFF_WDOG_ARM && !sys_reset
        && reg_wdata != `WRC_ARM_FIRST && reg_wdata != `WRC_ARM_SECOND;
    logic bad_q;
    logic trk_q;
    logic clr_q;
    logic [7:0] drv_q;
    logic [7:0] rel_q;
    // drive length is only judged for sequences started by a bad arm write,
    // since other causes may hold the pin through the quality check
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bad_q <= 1'b0;
            trk_q <= 1'b0;
            clr_q <= 1'b0;
            drv_q <= 8'h00;
            rel_q <= 8'h00;
        end
        else
        begin
            bad_q <= bad_wr;
            trk_q <= reset_pin_oe && (trk_q || bad_q);
            clr_q <= reg_wr && (reg_addr == `WRC_OFF_IRQ_CLR || reg_addr == `WRC_OFF_IRQ_EN);
            drv_q <= reset_pin_oe ? drv_q + 8'h01 : 8'h00;
            rel_q <= (sys_reset && !reset_pin_oe) ? rel_q + 8'h01 : 8'h00;
        end
    end
    sequence s_bad_arm;
        bad_wr;
    endsequence
    sequence s_pin_rise;
        $rose(reset_pin_in) ##1 $stable(oscillator_type_select) [*2];
    endsequence
    property p_pin_low;
        reset_pin_out == 1'b0 && (!reset_pin_oe || sys_reset);
    endproperty
    a_pin_low: assert property (p_pin_low)
        else $error("reset pin output not low");
    property p_bad_arm;
        s_bad_arm |=> sys_reset && reset_pin_oe;
    endproperty
    a_bad_arm: assert property (p_bad_arm)
        else $error("bad arm value did not reset");
    property p_drive_len;
        $fell(reset_pin_oe) && trk_q |-> drv_q == 8'h83;
    endproperty
    a_drive_len: assert property (p_drive_len)
        else $error("reset pin drive length wrong");
    property p_wait_len;
        $fell(sys_reset) |-> rel_q >= 8'h40 && rel_q <= 8'h42 && reset_pin_in;
    endproperty
    a_wait_len: assert property (p_wait_len)
        else $error("reset released without the wait");
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside answer cycle");
    property p_status_rd;
        reg_rd && reg_addr == `WRC_OFF_STATUS |=>
            reg_rdata[1:0] == $past({osc_full_swing, self_clock_mode});
    endproperty
    a_status_rd: assert property (p_status_rd)
        else $error("status read disagrees with outputs");
    property p_osc_cap;
        s_pin_rise |-> ##[0:2] osc_full_swing == oscillator_type_select;
    endproperty
    a_osc_cap: assert property (p_osc_cap)
        else $error("oscillator select not captured");
    property p_irq_hold;
        irq && !clr_q && !(reg_wr && (reg_addr == `WRC_OFF_IRQ_CLR
            || reg_addr == `WRC_OFF_IRQ_EN)) |=> irq || sys_reset;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("interrupt dropped without clear");
endmodule // wrc_top_chk
`default_nettype wire

// *** bench/tb.sv ***
/*
 * Self-checking bench of the watchdog, reset and clock-event block.
 * Assumes the oscillator model and checker are compiled before it.
 */
`default_nettype none
`include "wrc_map.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic por_event = 1'b0;
    logic lvr_event = 1'b0;
    logic stop_wake = 1'b0;
    logic pseudo_stop = 1'b0;
    logic oscillator_type_select = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic osc_bad = 1'b0;
    logic lock_cmd = 1'b0;
    logic loss_cmd = 1'b0;
    logic rd_seen = 1'b0;
    logic [15:0] v;
    logic [15:0] exp_q[$];
    logic [15:0] msk_q[$];
    int miscompares = 0;
    int samples_checked = 0;
    int seed = 32'h0C56;
    wire qual_ok, qual_good, pll_lock, clk_loss, reset_pin_in, reset_pin_out;
    wire reset_pin_oe, sys_reset, self_clock_mode, osc_full_swing, irq;
    wire [15:0] reg_rdata;
    wrc_top #(.WD_BASE_CYC(16), .TICK_BASE_CYC(4)) wrc_top_inst (.*);
    wrc_osc_model wrc_osc_model_inst (.*);
    always #12.5 mclk = !mclk;
    task automatic check(input logic [15:0] seen, input logic [15:0] e);
        samples_checked++;
        if (seen !== e)
        begin
            miscompares++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, e);
        end
    endtask
    task automatic chk1(input logic seen, input logic e);
        check({15'h0000, seen}, {15'h0000, e});
    endtask
    task automatic conclude();
        if (miscompares == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask
    task automatic arm();
        wr(`WRC_OFF_WDOG_ARM, `WRC_ARM_FIRST);
        wr(`WRC_OFF_WDOG_ARM, `WRC_ARM_SECOND);
    endtask
    task automatic wait_sr(input logic lvl, input int lim);
        int n;
        n = 0;
        while (sys_reset !== lvl && n < lim)
        begin
            @(posedge mclk);
            n++;
        end
        chk1(sys_reset, lvl);
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge mclk)
    begin
        if (rd_seen)
            check(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
        rd_seen = reg_rd;
    end
    initial
    begin
        cyc(20);
        rst_b <= 1'b1;
        wait_sr(1'b0, 800);
        rd(`WRC_OFF_STATUS, 16'h0002, 16'h000F);
        rd(`WRC_OFF_CLK_CTRL, `WRC_CLK_CTRL_RST, 16'h0007);
        rd(4'hF, 16'h0000, 16'hFFFF);
        oscillator_type_select <= 1'b0;
        wr(`WRC_OFF_TICK_CTRL, 16'h0001);
        cyc(20);
        chk1(irq, 1'b0);
        wr(`WRC_OFF_IRQ_CLR, 16'h0000);
        rd(`WRC_OFF_IRQ_STAT, 16'h0001, 16'h0001);
        rd(`WRC_OFF_STATUS, 16'h0002, 16'h0002);
        wr(`WRC_OFF_IRQ_EN, 16'h0001);
        cyc(2);
        chk1(irq, 1'b1);
        wr(`WRC_OFF_TICK_CTRL, 16'h0000);
        wr(`WRC_OFF_IRQ_CLR, 16'h0007);
        cyc(2);
        chk1(irq, 1'b0);
        pseudo_stop <= 1'b1;
        wr(`WRC_OFF_TICK_CTRL, 16'h0001);
        cyc(20);
        rd(`WRC_OFF_IRQ_STAT, 16'h0000, 16'h0001);
        wr(`WRC_OFF_CLK_CTRL, 16'h0007);
        cyc(20);
        rd(`WRC_OFF_IRQ_STAT, 16'h0001, 16'h0001);
        pseudo_stop <= 1'b0;
        wr(`WRC_OFF_TICK_CTRL, 16'h0000);
        wr(`WRC_OFF_IRQ_CLR, 16'h0007);
        wr(`WRC_OFF_IRQ_EN, 16'h0002);
        lock_cmd <= 1'b1;
        cyc(6);
        chk1(irq, 1'b1);
        rd(`WRC_OFF_IRQ_STAT, 16'h0002, 16'h0003);
        wr(`WRC_OFF_IRQ_CLR, 16'h0002);
        lock_cmd <= 1'b0;
        cyc(6);
        rd(`WRC_OFF_IRQ_STAT, 16'h0002, 16'h0002);
        wr(`WRC_OFF_IRQ_CLR, 16'h0002);
        wr(`WRC_OFF_WDOG_CTRL, 16'h0001);
        repeat (5)
        begin
            arm();
            cyc(8);
        end
        chk1(sys_reset, 1'b0);
        repeat (3)
        begin
            wr(`WRC_OFF_WDOG_ARM, `WRC_ARM_SECOND);
            cyc(4);
        end
        wait_sr(1'b1, 20);
        wait_sr(1'b0, 800);
        rd(`WRC_OFF_STATUS, 16'h0008, 16'h000E);
        wr(`WRC_OFF_WDOG_CTRL, 16'h000A);
        cyc(25);
        arm();
        chk1(sys_reset, 1'b0);
        wr(`WRC_OFF_WDOG_ARM, `WRC_ARM_FIRST);
        cyc(1);
        chk1(sys_reset, 1'b1);
        wait_sr(1'b0, 800);
        repeat (2)
        begin
            v = 16'($random(seed));
            if (v == `WRC_ARM_FIRST || v == `WRC_ARM_SECOND)
                v = 16'h0001;
            wr(`WRC_OFF_WDOG_CTRL, 16'h0007);
            wr(`WRC_OFF_WDOG_ARM, v);
            cyc(1);
            chk1(sys_reset, 1'b1);
            wait_sr(1'b0, 800);
        end
        osc_bad <= 1'b1;
        lvr_event <= 1'b1;
        @(posedge mclk);
        lvr_event <= 1'b0;
        wait_sr(1'b1, 5);
        wait_sr(1'b0, 1000);
        chk1(self_clock_mode, 1'b1);
        rd(`WRC_OFF_IRQ_STAT, 16'h0004, 16'h0004);
        chk1(irq, 1'b0);
        wr(`WRC_OFF_IRQ_EN, 16'h0004);
        cyc(2);
        chk1(irq, 1'b1);
        wr(`WRC_OFF_IRQ_CLR, 16'h0004);
        cyc(2);
        chk1(irq, 1'b0);
        osc_bad <= 1'b0;
        cyc(20);
        chk1(self_clock_mode, 1'b0);
        rd(`WRC_OFF_IRQ_STAT, 16'h0004, 16'h0004);
        loss_cmd <= 1'b1;
        cyc(6);
        chk1(self_clock_mode, 1'b1);
        loss_cmd <= 1'b0;
        cyc(20);
        wr(`WRC_OFF_CLK_CTRL, 16'h0001);
        loss_cmd <= 1'b1;
        wait_sr(1'b1, 8);
        loss_cmd <= 1'b0;
        wait_sr(1'b0, 1000);
        rd(`WRC_OFF_STATUS, 16'h0004, 16'h000C);
        por_event <= 1'b1;
        @(posedge mclk);
        por_event <= 1'b0;
        wait_sr(1'b1, 5);
        wait_sr(1'b0, 1000);
        rd(`WRC_OFF_STATUS, 16'h0000, 16'h000C);
        osc_bad <= 1'b1;
        stop_wake <= 1'b1;
        @(posedge mclk);
        stop_wake <= 1'b0;
        wait_sr(1'b1, 5);
        wait_sr(1'b0, 1000);
        chk1(self_clock_mode, 1'b1);
        cyc(3);
        conclude();
    end
    initial
    begin
        #(25 * 20000);
        miscompares++;
        conclude();
    end
endmodule // tb
bind wrc_top wrc_top_chk #(.WD_BASE_CYC(WD_BASE_CYC), .TICK_BASE_CYC(TICK_BASE_CYC))
    wrc_top_chk_inst (.*);
`default_nettype wire
